/* File: src/xazs_pkg.sv */
// Constants shared by the exclusive-OR and test-and-skip execution block.
package xazs_pkg;

   // Register byte offsets on the APB bus.
   localparam logic [7:0] ADDR_INSTR = 8'h00;
   localparam logic [7:0] ADDR_ACC = 8'h04;
   localparam logic [7:0] ADDR_BANK_SEL = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_MEM_ADDR = 8'h10;
   localparam logic [7:0] ADDR_MEM_DATA = 8'h14;
   localparam logic [7:0] ADDR_PC = 8'h18;

   // Reset values.
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [3:0] BANK_SEL_RESET = 4'h0;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [16:0] INSTR_RESET = 17'h00000;

   // Opcode patterns and operand bit positions.
   localparam logic [7:0] OPC_XOR_LIT = 8'h0a;
   localparam logic [5:0] OPC_XOR_REG = 6'h06;
   localparam logic [6:0] OPC_TST_SKIP = 7'h33;
   localparam int DEST_POS = 9;
   localparam int BANK_POS = 8;
   localparam int TWO_WORD_POS = 16;

   // Status register field positions.
   localparam int STAT_Z_POS = 2;
   localparam int STAT_N_POS = 4;
   localparam int STAT_BUSY_POS = 8;

   // Access bank: low part of bank 0 and high part of the top bank.
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

   // System clock cycles per quarter phase of the instruction cycle.
   localparam logic [3:0] QUARTER_DIV = 4'h4;
   localparam logic [1:0] NOP_ONE = 2'h1;
   localparam logic [1:0] NOP_TWO = 2'h2;
   localparam logic [1:0] QUARTER_LAST = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_Q1 = 3'b001,
      ST_Q2 = 3'b011,
      ST_Q3 = 3'b010,
      ST_Q4 = 3'b110,
      ST_NOP = 3'b111
   } xazs_state_t;

   typedef enum logic [1:0] {
      OP_NONE = 2'b00,
      OP_XOR_LIT = 2'b01,
      OP_XOR_REG = 2'b10,
      OP_TST_SKIP = 2'b11
   } xazs_op_t;

endpackage

/* File: src/xazs_qphase.sv */
// Quarter-phase enable generator dividing the system clock.
`timescale 1ns/10ps
`default_nettype none
module xazs_qphase (
   input wire logic i_clk,
   input wire logic i_rst_b,
   output logic o_tick
);
   import xazs_pkg::*;

   logic [3:0] div_reg;

   // Free running, so the first quarter of an instruction may wait up to one quarter.
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         div_reg <= 4'h0;
      end else if (div_reg == QUARTER_DIV - 4'h1) begin
         div_reg <= 4'h0;
      end else begin
         div_reg <= div_reg + 4'h1;
      end
   end

   assign o_tick = (div_reg == QUARTER_DIV - 4'h1);
endmodule
`default_nettype wire

/* File: src/xazs_core.sv */
// Executes the literal and register exclusive-OR and the test-and-skip instructions.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module xazs_core (
   input wire logic I_CLK_SYS,
   input wire logic I_RST_B,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   output logic [15:0] O_PC,
   output logic O_BUSY,
   output logic O_FLUSH,
   output logic O_SKIP
);
   import xazs_pkg::*;

   xazs_state_t state_reg;
   xazs_op_t op_reg;
   logic q_tick;
   logic [16:0] instr_reg;
   logic [7:0] acc_reg;
   logic [3:0] bank_sel_reg;
   logic [7:0] status_reg;
   logic [15:0] pc_reg;
   logic [11:0] mem_addr_reg;
   logic [11:0] ea_reg;
   logic [7:0] opnd_reg;
   logic [7:0] result_reg;
   logic [1:0] nop_left_reg;
   logic [1:0] nop_q_reg;
   logic skip_reg;
   logic [31:0] prdata_reg;
   logic [7:0] data_mem [0:4095];
   logic busy;
   logic setup;
   logic wr_take;
   logic mapped;
   logic refused;

   xazs_qphase u_qphase (
      .i_clk(I_CLK_SYS),
      .i_rst_b(I_RST_B),
      .o_tick(q_tick)
   );

   // Access-bank mapping avoids a bank select reload for common variables.
   function automatic logic [11:0] eff_addr(input logic [7:0] f, input logic a,
                                            input logic [3:0] bank);
      logic [11:0] ea;
      ea = {bank, f};
      if (!a) begin
         ea = (f < ACCESS_SPLIT) ? {ACCESS_LO_BANK, f} : {ACCESS_HI_BANK, f};
      end
      return ea;
   endfunction

   function automatic xazs_op_t decode(input logic [15:0] w);
      xazs_op_t k;
      k = OP_NONE;
      if (w[15:8] == OPC_XOR_LIT) begin
         k = OP_XOR_LIT;
      end else if (w[15:10] == OPC_XOR_REG) begin
         k = OP_XOR_REG;
      end else if (w[15:9] == OPC_TST_SKIP) begin
         k = OP_TST_SKIP;
      end
      return k;
   endfunction

   assign busy = (state_reg != ST_IDLE);
   assign setup = I_PSEL && !I_PENABLE;
   assign mapped = (I_PADDR == ADDR_INSTR) || (I_PADDR == ADDR_ACC) ||
                   (I_PADDR == ADDR_BANK_SEL) || (I_PADDR == ADDR_STATUS) ||
                   (I_PADDR == ADDR_MEM_ADDR) || (I_PADDR == ADDR_MEM_DATA) ||
                   (I_PADDR == ADDR_PC);
   // Writes during execution would race the pipeline, so they are refused.
   assign refused = !mapped || (I_PWRITE && busy);
   assign O_PREADY = I_PSEL && I_PENABLE;
   assign O_PSLVERR = O_PREADY && refused;
   assign wr_take = O_PREADY && I_PWRITE && !refused;

   // Read data is captured in the setup cycle so it comes from a flip-flop.
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         prdata_reg <= 32'h00000000;
      end else if (setup) begin
         case (I_PADDR)
            ADDR_INSTR: prdata_reg <= {15'h0000, instr_reg};
            ADDR_ACC: prdata_reg <= {24'h000000, acc_reg};
            ADDR_BANK_SEL: prdata_reg <= {28'h0000000, bank_sel_reg};
            ADDR_STATUS: prdata_reg <= {23'h000000, busy, status_reg};
            ADDR_MEM_ADDR: prdata_reg <= {20'h00000, mem_addr_reg};
            ADDR_MEM_DATA: prdata_reg <= {24'h000000, data_mem[mem_addr_reg]};
            ADDR_PC: prdata_reg <= {16'h0000, pc_reg};
            default: prdata_reg <= 32'h00000000;
         endcase
      end
   end
   assign O_PRDATA = prdata_reg;

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         state_reg <= ST_IDLE;
      end else if (wr_take && I_PADDR == ADDR_INSTR) begin
         state_reg <= ST_Q1;
      end else if (q_tick) begin
         case (state_reg)
            ST_Q1: state_reg <= ST_Q2;
            ST_Q2: state_reg <= ST_Q3;
            ST_Q3: state_reg <= ST_Q4;
            ST_Q4: begin
               if (op_reg == OP_TST_SKIP && opnd_reg == 8'h00) begin
                  state_reg <= ST_NOP;
               end else begin
                  state_reg <= ST_IDLE;
               end
            end
            ST_NOP: begin
               if (nop_q_reg == QUARTER_LAST && nop_left_reg == NOP_ONE) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         instr_reg <= INSTR_RESET;
      end else if (wr_take && I_PADDR == ADDR_INSTR) begin
         instr_reg <= I_PWDATA[16:0];
      end
   end

   // Decode quarter: kind of operation and effective register address.
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         op_reg <= OP_NONE;
         ea_reg <= 12'h000;
      end else if (q_tick && state_reg == ST_Q1) begin
         op_reg <= decode(instr_reg[15:0]);
         ea_reg <= eff_addr(instr_reg[7:0], instr_reg[BANK_POS], bank_sel_reg);
      end
   end

   // Operand read quarter and process quarter.
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         opnd_reg <= 8'h00;
         result_reg <= 8'h00;
      end else if (q_tick && state_reg == ST_Q2) begin
         if (op_reg == OP_XOR_LIT) begin
            opnd_reg <= instr_reg[7:0];
         end else begin
            opnd_reg <= data_mem[ea_reg];
         end
      end else if (q_tick && state_reg == ST_Q3) begin
         result_reg <= acc_reg ^ opnd_reg;
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         acc_reg <= ACC_RESET;
      end else if (wr_take && I_PADDR == ADDR_ACC) begin
         acc_reg <= I_PWDATA[7:0];
      end else if (q_tick && state_reg == ST_Q4) begin
         if (op_reg == OP_XOR_LIT ||
             (op_reg == OP_XOR_REG && !instr_reg[DEST_POS])) begin
            acc_reg <= result_reg;
         end
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (wr_take && I_PADDR == ADDR_MEM_DATA) begin
         data_mem[mem_addr_reg] <= I_PWDATA[7:0];
      end else if (q_tick && state_reg == ST_Q4 && op_reg == OP_XOR_REG &&
                   instr_reg[DEST_POS]) begin
         data_mem[ea_reg] <= result_reg;
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         status_reg <= STATUS_RESET;
      end else if (wr_take && I_PADDR == ADDR_STATUS) begin
         status_reg <= I_PWDATA[7:0];
      end else if (q_tick && state_reg == ST_Q4 &&
                   (op_reg == OP_XOR_LIT || op_reg == OP_XOR_REG)) begin
         status_reg[STAT_N_POS] <= result_reg[7];
         status_reg[STAT_Z_POS] <= (result_reg == 8'h00);
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         bank_sel_reg <= BANK_SEL_RESET;
         mem_addr_reg <= 12'h000;
      end else if (wr_take && I_PADDR == ADDR_BANK_SEL) begin
         bank_sel_reg <= I_PWDATA[3:0];
      end else if (wr_take && I_PADDR == ADDR_MEM_ADDR) begin
         mem_addr_reg <= I_PWDATA[11:0];
      end
   end

   // Each discarded word still advances the program counter.
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         pc_reg <= PC_RESET;
      end else if (wr_take && I_PADDR == ADDR_PC) begin
         pc_reg <= I_PWDATA[15:0];
      end else if (q_tick && (state_reg == ST_Q4 ||
                   (state_reg == ST_NOP && nop_q_reg == QUARTER_LAST))) begin
         pc_reg <= pc_reg + 16'h0001;
      end
   end

   // No-op cycle bookkeeping for a taken skip.
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         nop_left_reg <= 2'h0;
         nop_q_reg <= 2'h0;
         skip_reg <= 1'b0;
      end else begin
         skip_reg <= 1'b0;
         if (q_tick && state_reg == ST_Q4 && op_reg == OP_TST_SKIP &&
             opnd_reg == 8'h00) begin
            nop_left_reg <= instr_reg[TWO_WORD_POS] ? NOP_TWO : NOP_ONE;
            nop_q_reg <= 2'h0;
            skip_reg <= 1'b1;
         end else if (q_tick && state_reg == ST_NOP) begin
            nop_q_reg <= nop_q_reg + 2'h1;
            if (nop_q_reg == QUARTER_LAST) begin
               nop_left_reg <= nop_left_reg - 2'h1;
            end
         end
      end
   end

   assign O_PC = pc_reg;
   assign O_BUSY = busy;
   assign O_FLUSH = (state_reg == ST_NOP);
   assign O_SKIP = skip_reg;

   default clocking dflt_cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_B);

   logic [3:0] nop_ticks_reg;
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B || state_reg != ST_NOP) begin
         nop_ticks_reg <= 4'h0;
      end else if (q_tick) begin
         nop_ticks_reg <= nop_ticks_reg + 4'h1;
      end
   end

   a_lit_acc_update: assert property (
      (q_tick && state_reg == ST_Q4 && op_reg == OP_XOR_LIT)
      |=> acc_reg == ($past(acc_reg) ^ instr_reg[7:0]))
      else $error("literal xor result wrong");
   a_xor_flags_only: assert property (
      (q_tick && state_reg == ST_Q4 && (op_reg == OP_XOR_LIT || op_reg == OP_XOR_REG))
      |=> status_reg[STAT_N_POS] == $past(result_reg[7]) &&
          status_reg[STAT_Z_POS] == ($past(result_reg) == 8'h00) &&
          status_reg[1:0] == $past(status_reg[1:0]) &&
          status_reg[7:5] == $past(status_reg[7:5]) && status_reg[3] == $past(status_reg[3]))
      else $error("xor flags wrong");
   a_reg_dest_mem: assert property (
      (q_tick && state_reg == ST_Q4 && op_reg == OP_XOR_REG && instr_reg[DEST_POS])
      |=> data_mem[ea_reg] == $past(result_reg) && acc_reg == $past(acc_reg))
      else $error("register destination wrong");
   a_reg_dest_acc: assert property (
      (q_tick && state_reg == ST_Q3 && op_reg == OP_XOR_REG && !instr_reg[DEST_POS])
      |=> result_reg == (acc_reg ^ data_mem[ea_reg]))
      else $error("register xor operands wrong");
   a_bank_select: assert property (
      (state_reg == ST_Q2 && op_reg != OP_XOR_LIT)
      |-> (instr_reg[BANK_POS] ? ea_reg[11:8] == bank_sel_reg :
          (ea_reg[11:8] == ACCESS_LO_BANK || ea_reg[11:8] == ACCESS_HI_BANK)))
      else $error("bank selection wrong");
   a_no_skip_next: assert property (
      (q_tick && state_reg == ST_Q4 && op_reg == OP_TST_SKIP && opnd_reg != 8'h00)
      |=> state_reg == ST_IDLE && pc_reg == $past(pc_reg) + 16'h0001 && !O_SKIP)
      else $error("nonzero test skipped");
   a_skip_two_nops: assert property (
      (state_reg == ST_NOP && q_tick && nop_q_reg == QUARTER_LAST &&
       nop_left_reg == NOP_ONE && instr_reg[TWO_WORD_POS])
      |-> nop_ticks_reg == 4'h7)
      else $error("two-word skip length wrong");
   a_skip_one_nop: assert property (
      (q_tick && state_reg == ST_Q4 && op_reg == OP_TST_SKIP && opnd_reg == 8'h00 &&
       !instr_reg[TWO_WORD_POS])
      |=> O_SKIP && O_FLUSH && nop_left_reg == NOP_ONE)
      else $error("zero test did not flush");
   a_xor_one_cycle: assert property (
      (state_reg == ST_Q1 && q_tick && (decode(instr_reg[15:0]) == OP_XOR_LIT ||
                                        decode(instr_reg[15:0]) == OP_XOR_REG))
      |-> ##12 (q_tick && state_reg == ST_Q4) ##1 state_reg == ST_IDLE)
      else $error("xor not one cycle");

   c_lit: cover property (q_tick && state_reg == ST_Q4 && op_reg == OP_XOR_LIT);
   c_reg_to_mem: cover property (q_tick && state_reg == ST_Q4 && op_reg == OP_XOR_REG &&
                                 instr_reg[DEST_POS]);
   c_skip_one: cover property (O_SKIP && !instr_reg[TWO_WORD_POS]);
   c_skip_two: cover property (O_SKIP && instr_reg[TWO_WORD_POS]);
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking testbench for the exclusive-OR and test-and-skip execution block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp=%h got=%h", n, e, g); end end
module tb;
   import xazs_pkg::*;
   typedef struct {
      logic [16:0] ins;
      logic [7:0] acc, bank_select_register, md, st, xacc, xmd, xst;
      logic [11:0] ma;
      logic [1:0] pcd;
   } xazs_row_t;
   logic I_CLK_SYS = 1'b0;
   logic I_RST_B = 1'b0;
   logic I_PSEL = 1'b0;
   logic I_PENABLE = 1'b0;
   logic I_PWRITE = 1'b0;
   logic [7:0] I_PADDR = 8'h00;
   logic [31:0] I_PWDATA = 32'h0;
   logic [31:0] O_PRDATA;
   logic O_PREADY, O_PSLVERR, O_BUSY, O_FLUSH, O_SKIP;
   logic [15:0] O_PC;
   int errors = 0;
   int checked = 0;
   int skc = 0;
   int flc = 0;
   int bsc = 0;
   xazs_row_t rows [11];

   xazs_core uut (.I_CLK_SYS(I_CLK_SYS), .I_RST_B(I_RST_B), .I_PSEL(I_PSEL),
      .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
      .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_PC(O_PC),
      .O_BUSY(O_BUSY), .O_FLUSH(O_FLUSH), .O_SKIP(O_SKIP));

   always #2 I_CLK_SYS = ~I_CLK_SYS;

   // Sampling on the falling edge keeps the counts clear of the edge the design updates on.
   always @(negedge I_CLK_SYS) begin
      skc = skc + int'(O_SKIP === 1'b1);
      flc = flc + int'(O_FLUSH === 1'b1);
      bsc = bsc + int'(O_BUSY === 1'b1);
   end

   task automatic end_of_test;
      $display("checked=%0d errors=%0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      @(posedge I_CLK_SYS);
      I_PSEL <= 1'b1;
      I_PENABLE <= 1'b0;
      I_PWRITE <= w;
      I_PADDR <= a;
      I_PWDATA <= d;
      @(posedge I_CLK_SYS);
      I_PENABLE <= 1'b1;
      do @(posedge I_CLK_SYS); while (O_PREADY !== 1'b1);
      r = O_PRDATA;
      e = O_PSLVERR;
      I_PSEL <= 1'b0;
      I_PENABLE <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask

   // A new instruction must not be written until the previous one has retired.
   task automatic wait_idle;
      @(negedge I_CLK_SYS);
      for (int k = 0; k < 100 && O_BUSY !== 1'b0; k++) @(negedge I_CLK_SYS);
      `CHK("busy_end", 1'b0, O_BUSY)
   endtask

   initial begin
      repeat (20000) @(posedge I_CLK_SYS);
      errors++;
      end_of_test();
   end

   initial begin
      xazs_row_t r;
      logic [31:0] v, pc0;
      logic e;
      rows[0] = '{17'h00aaf, 8'hb5, 8'h3, 8'h3c, 8'h00, 8'h1a, 8'h3c, 8'h00, 12'h000, 2'd1};
      rows[1] = '{17'h00a5a, 8'h5a, 8'h0, 8'h3c, 8'heb, 8'h00, 8'h3c, 8'hef, 12'h000, 2'd1};
      rows[2] = '{17'h00af0, 8'h0f, 8'h0, 8'h3c, 8'h14, 8'hff, 8'h3c, 8'h10, 12'h000, 2'd1};
      rows[3] = '{17'h01820, 8'hb5, 8'h3, 8'haf, 8'hff, 8'h1a, 8'haf, 8'heb, 12'h020, 2'd1};
      rows[4] = '{17'h01a80, 8'hb5, 8'h3, 8'haf, 8'h00, 8'hb5, 8'h1a, 8'h00, 12'hf80, 2'd1};
      rows[5] = '{17'h01b33, 8'h80, 8'h5, 8'h80, 8'h00, 8'h80, 8'h00, 8'h04, 12'h533, 2'd1};
      rows[6] = '{17'h0197f, 8'h01, 8'h2, 8'hfe, 8'h00, 8'hff, 8'hfe, 8'h10, 12'h27f, 2'd1};
      rows[7] = '{17'h06610, 8'h00, 8'h0, 8'h01, 8'h55, 8'h00, 8'h01, 8'h55, 12'h010, 2'd1};
      rows[8] = '{17'h06744, 8'h00, 8'h7, 8'h00, 8'h55, 8'h00, 8'h00, 8'h55, 12'h744, 2'd2};
      rows[9] = '{17'h16661, 8'h00, 8'h7, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 12'hf61, 2'd3};
      // An opcode outside the three decoded ones must act as a plain one-cycle no-op.
      rows[10] = '{17'h0f000, 8'h5a, 8'h1, 8'h66, 8'h21, 8'h5a, 8'h66, 8'h21, 12'h100, 2'h1};
      repeat (20) @(posedge I_CLK_SYS);
      I_RST_B <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         r = rows[i];
         wr(ADDR_ACC, 32'(r.acc));
         wr(ADDR_BANK_SEL, 32'(r.bank_select_register));
         wr(ADDR_STATUS, 32'(r.st));
         wr(ADDR_MEM_ADDR, 32'(r.ma));
         wr(ADDR_MEM_DATA, 32'(r.md));
         rd(ADDR_PC, pc0);
         skc = 0;
         flc = 0;
         bsc = 0;
         wr(ADDR_INSTR, 32'(r.ins));
         wait_idle();
         rd(ADDR_ACC, v);
         `CHK("acc", 32'(r.xacc), v)
         rd(ADDR_STATUS, v);
         `CHK("status", 32'(r.xst), v)
         rd(ADDR_MEM_DATA, v);
         `CHK("mem", 32'(r.xmd), v)
         rd(ADDR_PC, v);
         `CHK("pc", pc0 + 32'(r.pcd), v)
         `CHK("o_pc", 16'(pc0 + 32'(r.pcd)), O_PC)
         `CHK("skips", int'(r.pcd > 2'd1), skc)
         `CHK("flush", 16 * (int'(r.pcd) - 1), flc)
         `CHK("span", 1'b1, (bsc - flc >= 13) && (bsc - flc <= 16))
      end
      // A write that lands mid-instruction is refused and must not disturb the result.
      wr(ADDR_ACC, 32'h30);
      wr(ADDR_STATUS, 32'h0);
      apb(1'b1, ADDR_INSTR, 32'h00a0f, v, e);
      apb(1'b1, ADDR_ACC, 32'h77, v, e);
      `CHK("busy_wr_err", 1'b1, e)
      rd(ADDR_STATUS, v);
      `CHK("busy_bit", 1'b1, v[STAT_BUSY_POS])
      wait_idle();
      rd(ADDR_ACC, v);
      `CHK("acc_kept", 32'h3f, v)
      apb(1'b0, 8'h1c, 32'h0, v, e);
      `CHK("unmapped", 33'h100000000, {e, v})
      wr(ADDR_BANK_SEL, 32'hffffffff);
      rd(ADDR_BANK_SEL, v);
      `CHK("bsel_width", 32'h0000000f, v)
      // Reset lands inside a long skip, so it must abort the no-op cycles too.
      wr(ADDR_INSTR, 32'h16661);
      repeat (20) @(negedge I_CLK_SYS);
      `CHK("flush_mid", 1'b1, O_FLUSH)
      @(posedge I_CLK_SYS);
      I_RST_B <= 1'b0;
      repeat (2) @(posedge I_CLK_SYS);
      I_RST_B <= 1'b1;
      rd(ADDR_ACC, v);
      `CHK("rst_acc", 32'(ACC_RESET), v)
      rd(ADDR_STATUS, v);
      `CHK("rst_status", 32'(STATUS_RESET), v)
      rd(ADDR_BANK_SEL, v);
      `CHK("rst_bank", 32'(BANK_SEL_RESET), v)
      rd(ADDR_PC, v);
      `CHK("rst_pc", 32'(PC_RESET), v)
      `CHK("rst_o_pc", PC_RESET, O_PC)
      `CHK("rst_outs", 3'h0, {O_BUSY, O_FLUSH, O_SKIP})
      end_of_test();
   end
endmodule
`default_nettype wire
